// >>> ir_dual_counter_timer.sv
`timescale 1ns/100ps
module ir_dual_counter_timer
   import ir_timer_pkg::*;
#(
   parameter logic [7:0] FILTER_STEP = FILTER_STEP_DEF
)(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        demod_mode_i,
   input  wire logic [1:0]  out_mode_i,
   input  wire logic [1:0]  edge_sel_i,
   input  wire logic        init_level_wide_i,
   input  wire logic        init_level_narrow_i,
   input  wire logic        combine_en_i,
   input  wire logic [1:0]  combine_sel_i,
   input  wire logic [1:0]  wide_clk_sel_i,
   input  wire logic        wide_single_i,
   input  wire logic        narrow_single_i,
   input  wire logic        wide_en_wr_i,
   input  wire logic        wide_en_wdata_i,
   input  wire logic        narrow_en_wr_i,
   input  wire logic        narrow_en_wdata_i,
   input  wire logic        wide_timeout_clr_i,
   input  wire logic        narrow_timeout_clr_i,
   input  wire logic        edge_rise_clr_i,
   input  wire logic        edge_fall_clr_i,
   input  wire logic        capture_int_mask_i,
   input  wire logic        wide_int_mask_i,
   input  wire logic        narrow_int_mask_i,
   input  wire logic [7:0]  wide_reload_high_i,
   input  wire logic [7:0]  wide_reload_low_i,
   input  wire logic [7:0]  narrow_reload_high_i,
   input  wire logic [7:0]  narrow_reload_low_i,
   input  wire logic        narrow_pin_sel_i,
   input  wire logic        wide_pin_sel_i,
   input  wire logic [2:0]  port_data_i,
   input  wire logic        ir_in_i,
   output logic             wide_enable_o,
   output logic             narrow_enable_o,
   output logic [15:0]      wide_count_o,
   output logic [15:0]      wide_capture_o,
   output logic             wide_timeout_o,
   output logic             narrow_timeout_o,
   output logic             edge_rise_o,
   output logic             edge_fall_o,
   output logic             wide_timeout_req_o,
   output logic             narrow_timeout_req_o,
   output logic             capture_req_o,
   output logic             wide_out_o,
   output logic             narrow_out_o,
   output logic             narrow_out_pin_o,
   output logic             wide_out_pin_o,
   output logic             combined_out_pin_o
);

   logic [PRESCALE_W-1:0] pre_reg;
   logic [7:0]            filt_cnt_reg;
   logic                  filt_lvl_reg;
   logic                  filt_prev_reg;
   logic [15:0]           wide_cnt_reg;
   logic                  wide_en_reg;
   logic                  wide_lvl_reg;
   logic                  wide_armed_reg;
   logic                  single_prev_reg;
   logic [7:0]            narrow_cnt_reg;
   logic                  narrow_en_reg;
   logic                  narrow_lvl_reg;

   // Prescaler tick for the wide counter
   wire wide_tick = (wide_clk_sel_i == CLK_DIV1) ? 1'b1 :
                    (wide_clk_sel_i == CLK_DIV2) ? pre_reg[0] :
                    (wide_clk_sel_i == CLK_DIV4) ? (&pre_reg[1:0]) :
                    (&pre_reg);

   // Glitch filter width comes from the output-mode field only in demodulation
   wire [1:0] filt_code  = demod_mode_i ? out_mode_i : 2'h0;
   wire [7:0] filt_limit = 8'({6'h0, filt_code} * FILTER_STEP);
   wire       filt_same  = (ir_in_i == filt_lvl_reg);
   wire       filt_take  = !filt_same && (filt_cnt_reg >= filt_limit);
   wire       rise_pulse = filt_lvl_reg && !filt_prev_reg;
   wire       fall_pulse = !filt_lvl_reg && filt_prev_reg;
   wire       sel_edge   = (rise_pulse && edge_sel_i[EDGE_RISE_BIT]) ||
                           (fall_pulse && edge_sel_i[EDGE_FALL_BIT]);

   // Mode decode; the mode field going to 00 simply drops the hand-over
   wire pingpong   = !demod_mode_i && (out_mode_i == OUT_MODE_PINGPONG);
   wire [15:0] wide_reload = {wide_reload_high_i, wide_reload_low_i};

   // Narrow counter events; it counts every system clock
   wire narrow_term      = narrow_en_reg && (narrow_cnt_reg == NARROW_ONE);
   wire narrow_stop_term = narrow_term && (narrow_single_i || pingpong);
   wire narrow_sw_start  = narrow_en_wr_i && narrow_en_wdata_i && !narrow_en_reg;
   wire narrow_sw_stop   = narrow_en_wr_i && !narrow_en_wdata_i;

   // Wide counter events
   wire wide_run       = wide_en_reg && !wide_armed_reg;
   wire wide_term      = wide_run && wide_tick && (wide_cnt_reg == WIDE_ONE);
   wire wide_wrap      = wide_run && wide_tick && (wide_cnt_reg == WIDE_ZERO);
   wire wide_stop_term = wide_term && !demod_mode_i && (wide_single_i || pingpong);
   wire wide_sw_start  = wide_en_wr_i && wide_en_wdata_i && !wide_en_reg;
   wire wide_sw_stop   = wide_en_wr_i && !wide_en_wdata_i;
   wire wide_start     = wide_sw_start || (pingpong && narrow_term);
   wire narrow_start   = narrow_sw_start || (pingpong && wide_term);

   // Demodulation edge handling
   wire edge_take   = demod_mode_i && wide_en_reg && sel_edge &&
                      (wide_armed_reg || !wide_single_i);
   wire edge_status = edge_take && !wide_armed_reg;
   wire narrow_cap  = demod_mode_i && wide_run && wide_single_i && narrow_term;
   wire rearm       = demod_mode_i && wide_en_reg && wide_single_i && !single_prev_reg;

   // Wide counter next count; the edge reload has priority over a tick
   wire [15:0] wide_dec      = wide_cnt_reg - WIDE_ONE;
   wire [15:0] wide_term_val = (demod_mode_i || wide_single_i || pingpong) ?
                               WIDE_ZERO : wide_reload;
   wire [15:0] wide_cnt_next =
      wide_start                ? wide_reload :
      edge_take                 ? WIDE_ALL_ONES :
      wide_term                 ? wide_term_val :
      wide_wrap                 ? WIDE_ALL_ONES :
      (wide_run && wide_tick)   ? wide_dec : wide_cnt_reg;

   wire wide_en_next = wide_start ? 1'b1 :
                       (wide_stop_term || wide_sw_stop) ? 1'b0 : wide_en_reg;
   wire wide_lvl_next = wide_start ? init_level_wide_i :
                        (wide_term && !demod_mode_i) ? !wide_lvl_reg : wide_lvl_reg;
   wire wide_armed_next = (wide_start && demod_mode_i) || (rearm && !edge_take) ? 1'b1 :
                          edge_take ? 1'b0 : wide_armed_reg;

   // Narrow counter next count; in modulo-N the new level picks the reload byte
   wire [7:0] narrow_first    = init_level_narrow_i ? narrow_reload_high_i : narrow_reload_low_i;
   wire [7:0] narrow_mod_val  = narrow_lvl_reg ? narrow_reload_low_i : narrow_reload_high_i;
   wire [7:0] narrow_dec      = narrow_cnt_reg - NARROW_ONE;
   wire [7:0] narrow_cnt_next =
      narrow_start       ? narrow_first :
      narrow_stop_term   ? NARROW_ZERO :
      narrow_term        ? narrow_mod_val :
      !narrow_en_reg     ? narrow_cnt_reg :
      (narrow_cnt_reg == NARROW_ZERO) ? NARROW_ALL : narrow_dec;
   wire narrow_en_next = narrow_start ? 1'b1 :
                         (narrow_stop_term || narrow_sw_stop) ? 1'b0 : narrow_en_reg;
   wire narrow_lvl_next = narrow_start ? init_level_narrow_i :
                          narrow_term ? !narrow_lvl_reg : narrow_lvl_reg;

   // Timer outputs; forcing acts on the wide output only and only exists in transmit since the field is the filter otherwise
   wire force_out     = !demod_mode_i && out_mode_i[1];
   wire wide_out_next = force_out ? (out_mode_i == OUT_MODE_FORCE1) :
                        wide_en_next ? wide_lvl_next : !init_level_wide_i;
   wire narrow_out_next = narrow_en_next ? narrow_lvl_next : !init_level_narrow_i;
   wire comb_next = (combine_sel_i == COMB_AND) ? (wide_out_next & narrow_out_next) :
                    (combine_sel_i == COMB_OR)  ? (wide_out_next | narrow_out_next) :
                    (combine_sel_i == COMB_XOR) ? (wide_out_next ^ narrow_out_next) :
                    !(wide_out_next & narrow_out_next);

   // Prescaler and glitch filter
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         pre_reg       <= '0;
         filt_cnt_reg  <= FILTER_CNT_ZERO;
         filt_lvl_reg  <= 1'b0;
         filt_prev_reg <= 1'b0;
      end
      else
      begin
         pre_reg       <= pre_reg + 3'h1;
         filt_cnt_reg  <= (filt_same || filt_take) ? FILTER_CNT_ZERO : filt_cnt_reg + 8'h01;
         filt_lvl_reg  <= filt_take ? ir_in_i : filt_lvl_reg;
         filt_prev_reg <= filt_lvl_reg;
      end
   end

   // Counter state
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         wide_cnt_reg    <= WIDE_ZERO;
         wide_en_reg     <= 1'b0;
         wide_lvl_reg    <= 1'b0;
         wide_armed_reg  <= 1'b0;
         single_prev_reg <= 1'b0;
         narrow_cnt_reg  <= NARROW_ZERO;
         narrow_en_reg   <= 1'b0;
         narrow_lvl_reg  <= 1'b0;
      end
      else
      begin
         wide_cnt_reg    <= wide_cnt_next;
         wide_en_reg     <= wide_en_next;
         wide_lvl_reg    <= wide_lvl_next;
         wide_armed_reg  <= wide_armed_next;
         single_prev_reg <= wide_single_i;
         narrow_cnt_reg  <= narrow_cnt_next;
         narrow_en_reg   <= narrow_en_next;
         narrow_lvl_reg  <= narrow_lvl_next;
      end
   end

   // Status, capture and requests; a setting event beats a clear in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         wide_timeout_o       <= 1'b0;
         narrow_timeout_o     <= 1'b0;
         edge_rise_o          <= 1'b0;
         edge_fall_o          <= 1'b0;
         wide_capture_o       <= WIDE_ZERO;
         wide_timeout_req_o   <= 1'b0;
         narrow_timeout_req_o <= 1'b0;
         capture_req_o        <= 1'b0;
      end
      else
      begin
         wide_timeout_o   <= wide_term || (wide_timeout_o && !wide_timeout_clr_i);
         narrow_timeout_o <= narrow_term || (narrow_timeout_o && !narrow_timeout_clr_i);
         edge_rise_o      <= (edge_status && rise_pulse) || (edge_rise_o && !edge_rise_clr_i);
         edge_fall_o      <= (edge_status && fall_pulse) || (edge_fall_o && !edge_fall_clr_i);
         if (edge_take || narrow_cap)
            wide_capture_o <= ~wide_cnt_reg;
         wide_timeout_req_o   <= wide_term && wide_int_mask_i;
         narrow_timeout_req_o <= narrow_term && narrow_int_mask_i;
         capture_req_o        <= (edge_status || narrow_cap) && capture_int_mask_i;
      end
   end

   // Registered timer outputs and pin routing
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         wide_out_o         <= 1'b1;
         narrow_out_o       <= 1'b1;
         narrow_out_pin_o   <= 1'b0;
         wide_out_pin_o     <= 1'b0;
         combined_out_pin_o <= 1'b0;
      end
      else
      begin
         wide_out_o         <= wide_out_next;
         narrow_out_o       <= narrow_out_next;
         narrow_out_pin_o   <= narrow_pin_sel_i ? narrow_out_next : port_data_i[0];
         wide_out_pin_o     <= wide_pin_sel_i ? wide_out_next : port_data_i[1];
         combined_out_pin_o <= combine_en_i ? comb_next : port_data_i[2];
      end
   end

   assign wide_enable_o   = wide_en_reg;
   assign narrow_enable_o = narrow_en_reg;
   assign wide_count_o    = wide_cnt_reg;

   // Checks next to the logic
   property p_disabled_level;
      @(posedge clk_i) disable iff (!rst_n_i)
      (!wide_en_next && !demod_mode_i && !out_mode_i[1]) |=> (wide_out_o == !$past(init_level_wide_i));
   endproperty
   a_disabled_level: assert property (p_disabled_level) else $error("disabled level wrong");

   property p_force;
      @(posedge clk_i) disable iff (!rst_n_i)
      (!demod_mode_i && out_mode_i[1]) |=> (wide_out_o == $past(out_mode_i[0]));
   endproperty
   a_force: assert property (p_force) else $error("forced level wrong");

   property p_load;
      @(posedge clk_i) disable iff (!rst_n_i)
      wide_start |=> (wide_count_o == $past(wide_reload)) && (wide_lvl_reg == $past(init_level_wide_i));
   endproperty
   a_load: assert property (p_load) else $error("enable load wrong");

   property p_term_toggle;
      @(posedge clk_i) disable iff (!rst_n_i)
      (wide_term && !demod_mode_i && !wide_start) |=> wide_timeout_o && (wide_lvl_reg != $past(wide_lvl_reg));
   endproperty
   a_term_toggle: assert property (p_term_toggle) else $error("terminal toggle missing");

   property p_single_stop;
      @(posedge clk_i) disable iff (!rst_n_i)
      (wide_term && !demod_mode_i && wide_single_i && !wide_start) |=> !wide_enable_o ##1 !wide_enable_o || $past(wide_en_wr_i);
   endproperty
   a_single_stop: assert property (p_single_stop) else $error("single pass did not stop");

   property p_wrap;
      @(posedge clk_i) disable iff (!rst_n_i)
      (wide_wrap && !wide_start && !edge_take) |=> (wide_count_o == WIDE_ALL_ONES) ##1 !wide_timeout_req_o;
   endproperty
   a_wrap: assert property (p_wrap) else $error("zero wrap wrong");

   property p_edge_capture;
      @(posedge clk_i) disable iff (!rst_n_i)
      (edge_status && !wide_start) |=> (wide_count_o == WIDE_ALL_ONES) && (wide_capture_o == ~$past(wide_cnt_reg));
   endproperty
   a_edge_capture: assert property (p_edge_capture) else $error("edge capture wrong");

   property p_pingpong;
      @(posedge clk_i) disable iff (!rst_n_i)
      (pingpong && narrow_term && !wide_en_wr_i && !narrow_en_wr_i) |=> wide_enable_o && !narrow_enable_o;
   endproperty
   a_pingpong: assert property (p_pingpong) else $error("ping-pong hand-over wrong");

   property p_clear;
      @(posedge clk_i) disable iff (!rst_n_i)
      (wide_timeout_o && wide_timeout_clr_i && !wide_term) |=> !wide_timeout_o;
   endproperty
   a_clear: assert property (p_clear) else $error("timeout clear failed");

endmodule // ir_dual_counter_timer

// >>> ir_dual_counter_timer_tb_top.sv
`timescale 1ns/100ps
module ir_dual_counter_timer_tb_top;
   import ir_timer_pkg::*;
   localparam int CYCLE_LIMIT = 5000;
   logic clk_i = 1'b0, rst_n_i = 1'b0, demod_mode_i = 1'b0, combine_en_i = 1'b0;
   logic init_level_wide_i = 1'b0, init_level_narrow_i = 1'b0, ir_in_i;
   logic wide_single_i = 1'b1, narrow_single_i = 1'b1, wide_en_wr_i = 1'b0;
   logic wide_en_wdata_i = 1'b0, narrow_en_wr_i = 1'b0, narrow_en_wdata_i = 1'b0;
   logic wide_timeout_clr_i = 1'b0, narrow_timeout_clr_i = 1'b0, edge_rise_clr_i = 1'b0;
   logic edge_fall_clr_i = 1'b0, capture_int_mask_i = 1'b1, wide_int_mask_i = 1'b1;
   logic narrow_int_mask_i = 1'b1, narrow_pin_sel_i = 1'b0, wide_pin_sel_i = 1'b0;
   logic [1:0] out_mode_i = 2'h0, edge_sel_i = 2'h1, combine_sel_i = 2'h0, wide_clk_sel_i = 2'h0;
   logic [7:0] wide_reload_high_i = 8'h00, wide_reload_low_i = 8'h03;
   logic [7:0] narrow_reload_high_i = 8'h10, narrow_reload_low_i = 8'h10, pulse_len = 8'h14;
   logic [2:0] port_data_i = 3'h5;
   logic       pulse_req = 1'b0, saw_cap = 1'b0, a, b;
   logic       wide_enable_o, narrow_enable_o, wide_timeout_o, narrow_timeout_o, edge_rise_o;
   logic       edge_fall_o, wide_timeout_req_o, narrow_timeout_req_o, capture_req_o;
   logic       wide_out_o, narrow_out_o, narrow_out_pin_o, wide_out_pin_o, combined_out_pin_o;
   logic [15:0] wide_count_o, wide_capture_o, cap;
   int errors = 0, checks = 0, cycles = 0, n, k;

   ir_dual_counter_timer #(.FILTER_STEP(8'h01)) i_dut (.clk_i, .rst_n_i, .demod_mode_i,
      .out_mode_i, .edge_sel_i, .init_level_wide_i, .init_level_narrow_i, .combine_en_i,
      .combine_sel_i, .wide_clk_sel_i, .wide_single_i, .narrow_single_i, .wide_en_wr_i,
      .wide_en_wdata_i, .narrow_en_wr_i, .narrow_en_wdata_i, .wide_timeout_clr_i,
      .narrow_timeout_clr_i, .edge_rise_clr_i, .edge_fall_clr_i, .capture_int_mask_i,
      .wide_int_mask_i, .narrow_int_mask_i, .wide_reload_high_i, .wide_reload_low_i,
      .narrow_reload_high_i, .narrow_reload_low_i, .narrow_pin_sel_i, .wide_pin_sel_i,
      .port_data_i, .ir_in_i, .wide_enable_o, .narrow_enable_o, .wide_count_o,
      .wide_capture_o, .wide_timeout_o, .narrow_timeout_o, .edge_rise_o, .edge_fall_o,
      .wide_timeout_req_o, .narrow_timeout_req_o, .capture_req_o, .wide_out_o,
      .narrow_out_o, .narrow_out_pin_o, .wide_out_pin_o, .combined_out_pin_o);

   ir_edge_source i_src (.clk_i, .rst_n_i, .pulse_req_i(pulse_req), .pulse_len_i(pulse_len),
      .ir_in_o(ir_in_i));

   always #12.5 clk_i = ~clk_i;

   // Hang guard and capture request watcher; requests last one cycle only
   always @(posedge clk_i)
   begin
      cycles++;
      if (capture_req_o === 1'b1) saw_cap <= 1'b1;
      if (cycles == CYCLE_LIMIT)
      begin
         errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
      checks++;
      if ((got >= lo && got <= hi) !== 1'b1)
      begin
         errors++;
         $display("MISMATCH t=%0t got %h range %0d..%0d", $time, got, lo, hi);
      end
   endtask

   task automatic tick(input int cnt);
      repeat (cnt) @(posedge clk_i);
      #1;
   endtask

   // Enable write: one-cycle strobe, then settle 1 ns past the sampling edge
   task automatic wr_en(input bit narrow, input bit v);
      @(posedge clk_i);
      if (narrow) {narrow_en_wr_i, narrow_en_wdata_i} <= {1'b1, v};
      else {wide_en_wr_i, wide_en_wdata_i} <= {1'b1, v};
      @(posedge clk_i);
      {narrow_en_wr_i, wide_en_wr_i} <= 2'b00;
      #1;
   endtask

   task automatic clr_flags();
      @(posedge clk_i);
      {wide_timeout_clr_i, narrow_timeout_clr_i, edge_rise_clr_i, edge_fall_clr_i} <= 4'hf;
      @(posedge clk_i);
      {wide_timeout_clr_i, narrow_timeout_clr_i, edge_rise_clr_i, edge_fall_clr_i} <= 4'h0;
      #1;
   endtask

   task automatic pulse();
      @(posedge clk_i);
      pulse_req <= 1'b1;
      @(posedge clk_i);
      pulse_req <= 1'b0;
   endtask

   // Bounded wait on a timeout flag, n counts the edges waited
   task automatic wait_flag(input bit narrow, input int lim, output int cnt);
      cnt = 0;
      do
      begin
         tick(1);
         cnt++;
      end while ((narrow ? narrow_timeout_o : wide_timeout_o) !== 1'b1 && cnt < lim);
      chk({15'h0000, (narrow ? narrow_timeout_o : wide_timeout_o)}, 16'h0001);
   endtask

   initial
   begin
      tick(11);
      chk({wide_enable_o, narrow_enable_o, wide_timeout_o}, 16'h0000);
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      tick(3);
      chk(wide_out_o, 16'h0001);
      @(posedge clk_i);
      {init_level_wide_i, out_mode_i} <= {1'b1, OUT_MODE_FORCE1};
      tick(3);
      chk(wide_out_o, 16'h0001);
      @(posedge clk_i);
      {init_level_wide_i, out_mode_i} <= {1'b0, OUT_MODE_FORCE0};
      tick(3);
      chk(wide_out_o, 16'h0000);
      // Single pass: load, walk down, toggle, stop
      @(posedge clk_i);
      out_mode_i <= OUT_MODE_NORMAL;
      wr_en(1'b0, 1'b1);
      chk({wide_enable_o, wide_out_o, wide_count_o[13:0]}, 16'h8003);
      tick(2);
      chk({wide_timeout_o, wide_count_o[14:0]}, 16'h0001);
      tick(1);
      chk({wide_timeout_o, wide_timeout_req_o, wide_out_o, wide_count_o[12:0]}, 16'he000);
      tick(1);
      chk({wide_enable_o, wide_timeout_req_o}, 16'h0000);
      // Modulo-N with a reload byte changed mid-count
      clr_flags();
      @(posedge clk_i);
      {wide_single_i, wide_reload_low_i} <= {1'b0, 8'h02};
      wr_en(1'b0, 1'b1);
      chk(wide_count_o, 16'h0002);
      @(posedge clk_i);
      wide_reload_low_i <= 8'h05;
      tick(1);
      chk({wide_enable_o, wide_timeout_o, wide_count_o[13:0]}, 16'hc005);
      wr_en(1'b0, 1'b0);
      tick(3);
      chk(wide_timeout_o, 16'h0001);
      clr_flags();
      chk(wide_timeout_o, 16'h0000);
      // Count of zero wraps without a timeout
      @(posedge clk_i);
      {wide_single_i, wide_reload_low_i} <= {1'b1, 8'h00};
      wr_en(1'b0, 1'b1);
      tick(1);
      chk({wide_timeout_o, wide_count_o[14:0]}, 16'h7fff);
      wr_en(1'b0, 1'b0);
      // Every clock divider code, count of four
      for (k = 0; k < 4; k++)
      begin
         clr_flags();
         @(posedge clk_i);
         {wide_clk_sel_i, wide_reload_low_i} <= {k[1:0], 8'h04};
         wr_en(1'b0, 1'b1);
         wait_flag(1'b0, 64, n);
         chk_rng(n[15:0], 3 << k, (4 << k) + 1);
         tick(2);
      end
      // Pin routing and every combine function with both counters idle
      for (k = 0; k < 16; k++)
      begin
         @(posedge clk_i);
         {init_level_wide_i, init_level_narrow_i, combine_sel_i} <= k[3:0];
         {narrow_pin_sel_i, wide_pin_sel_i, combine_en_i} <= 3'b111;
         tick(3);
         a = ~k[3];
         b = ~k[2];
         cap = {13'h0000, k[1:0] == 0 ? a & b : k[1:0] == 1 ? a | b : k[1:0] == 2 ? a ^ b : ~(a & b),
            a, b};
         chk({combined_out_pin_o, wide_out_pin_o, narrow_out_pin_o}, cap);
      end
      @(posedge clk_i);
      {narrow_pin_sel_i, wide_pin_sel_i, combine_en_i} <= 3'b000;
      tick(3);
      chk({combined_out_pin_o, wide_out_pin_o, narrow_out_pin_o}, 16'h0005);
      // Demodulation: armed edge, measured edge, then single-edge mode
      @(posedge clk_i);
      {demod_mode_i, wide_single_i, wide_clk_sel_i} <= {1'b1, 1'b0, CLK_DIV1};
      {wide_reload_high_i, wide_reload_low_i} <= 16'hffff;
      wr_en(1'b0, 1'b1);
      clr_flags();
      pulse();
      tick(4);
      chk({edge_rise_o, saw_cap}, 16'h0000);
      tick(33);
      pulse();
      tick(4);
      chk({edge_rise_o, saw_cap}, 16'h0003);
      chk_rng(wide_capture_o, 36, 42);
      @(posedge clk_i);
      wide_single_i <= 1'b1;
      clr_flags();
      cap = wide_capture_o;
      // Let the measured pulse end first, else the next request makes no edge
      tick(20);
      @(posedge clk_i);
      {out_mode_i, pulse_len} <= {2'h2, 8'h01};
      pulse();
      tick(4);
      chk(wide_capture_o, cap);
      @(posedge clk_i);
      {out_mode_i, pulse_len} <= {2'h0, 8'h14};
      pulse();
      tick(4);
      chk(edge_rise_o, 16'h0000);
      chk({15'h0000, wide_capture_o != cap}, 16'h0001);
      chk_rng(wide_count_o, 16'hfffc, 16'hffff);
      tick(30);
      pulse();
      tick(4);
      chk({edge_rise_o, edge_fall_o}, 16'h0000);
      chk_rng(wide_count_o, 0, 16'hffe0);
      // Narrow timeout in single-edge mode captures without reloading the wide count
      cap = wide_capture_o;
      wr_en(1'b1, 1'b1);
      tick(20);
      chk({15'h0000, wide_capture_o != cap}, 16'h0001);
      chk_rng(wide_count_o, 0, 16'hffe0);
      // Ping-pong from idle, then stopped by mode 00
      wr_en(1'b0, 1'b0);
      @(posedge clk_i);
      {demod_mode_i, out_mode_i, narrow_single_i} <= {1'b0, OUT_MODE_PINGPONG, 1'b1};
      wide_reload_low_i <= 8'h05;
      wide_reload_high_i <= 8'h00;
      clr_flags();
      wr_en(1'b1, 1'b1);
      wait_flag(1'b1, 40, n);
      chk(narrow_timeout_req_o, 16'h0001);
      tick(2);
      chk({wide_enable_o, narrow_enable_o}, 16'h0002);
      wait_flag(1'b0, 40, n);
      tick(2);
      chk({wide_enable_o, narrow_enable_o}, 16'h0001);
      @(posedge clk_i);
      out_mode_i <= OUT_MODE_NORMAL;
      clr_flags();
      wait_flag(1'b1, 40, n);
      tick(3);
      chk({wide_enable_o, narrow_enable_o}, 16'h0000);
      report_and_stop();
   end
endmodule // ir_dual_counter_timer_tb_top

// >>> ir_edge_source.sv
`timescale 1ns/100ps
// Far-side carrier source: one clean high pulse per request, low while idle
module ir_edge_source
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       pulse_req_i,
   input  wire logic [7:0] pulse_len_i,
   output logic            ir_in_o
);
   logic [7:0] left_reg;

   // Width is held for the whole count so the glitch filter passes it when the count is longer than the filter width
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         left_reg <= 8'h00;
         ir_in_o  <= 1'b0;
      end
      else if (pulse_req_i)
      begin
         left_reg <= pulse_len_i;
         ir_in_o  <= 1'b1;
      end
      else if (left_reg != 8'h00)
      begin
         left_reg <= left_reg - 8'h01;
         ir_in_o  <= (left_reg != 8'h01);
      end
   end
endmodule // ir_edge_source

// >>> ir_timer_pkg.sv
package ir_timer_pkg;

   // Counter widths
   localparam int WIDE_W   = 16;
   localparam int NARROW_W = 8;

   // Shared control output-mode field in transmit mode
   localparam logic [1:0] OUT_MODE_NORMAL   = 2'h0;
   localparam logic [1:0] OUT_MODE_PINGPONG = 2'h1;
   localparam logic [1:0] OUT_MODE_FORCE0   = 2'h2;
   localparam logic [1:0] OUT_MODE_FORCE1   = 2'h3;

   // Wide counter clock divider codes (divide by 1, 2, 4, 8)
   localparam logic [1:0] CLK_DIV1 = 2'h0;
   localparam logic [1:0] CLK_DIV2 = 2'h1;
   localparam logic [1:0] CLK_DIV4 = 2'h2;
   localparam logic [1:0] CLK_DIV8 = 2'h3;
   localparam int         PRESCALE_W = 3;

   // Combine field encodings
   localparam logic [1:0] COMB_AND  = 2'h0;
   localparam logic [1:0] COMB_OR   = 2'h1;
   localparam logic [1:0] COMB_XOR  = 2'h2;
   localparam logic [1:0] COMB_NAND = 2'h3;

   // Edge select field bit positions
   localparam int EDGE_RISE_BIT = 0;
   localparam int EDGE_FALL_BIT = 1;

   // Count values
   localparam logic [15:0] WIDE_ONE      = 16'h0001;
   localparam logic [15:0] WIDE_ZERO     = 16'h0000;
   localparam logic [15:0] WIDE_ALL_ONES = 16'hFFFF;
   localparam logic [7:0]  NARROW_ONE    = 8'h01;
   localparam logic [7:0]  NARROW_ZERO   = 8'h00;
   localparam logic [7:0]  NARROW_ALL    = 8'hFF;

   // Glitch filter step per filter code, in system clocks
   localparam logic [7:0] FILTER_STEP_DEF = 8'h04;
   localparam logic [7:0] FILTER_CNT_ZERO = 8'h00;

endpackage
